// >>> hdl/srcd_top.sv
/*
 * SYSREF generator configuration slice: nine 16-bit registers on a plain
 * register port, a Sref_burst_enable generator in master, burst and repeater
 * modes, the delay trim values and the decoded channel divide ratio.
 * Assumes the request pin is asynchronous to clk and that clk stands in
 * for the synthesizer output frequency feeding the dividers.
 */
`timescale 1ns/100ps
`default_nettype none

module srcd_top (
    input wire logic clk,
    input wire logic rstn,
    input wire srcd_pkg::srcd_bus_req_t bus_req,
    output logic [srcd_pkg::DATA_W-1:0] bus_rdata,
    input wire logic sref_request_pin,
    output logic sysref_out,
    output srcd_pkg::srcd_trim_t sref_delay_trim,
    output logic [srcd_pkg::RATIO_W-1:0] output_channel_divisor
);
    import srcd_pkg::*;

    srcd_state_t st;
    srcd_state_t next_st;

    function automatic logic [RATIO_W-1:0] output_channel_divisor_ratio(input logic [OUTPUT_CHANNEL_DIVISOR_W-1:0] code);
        logic [RATIO_W-1:0] r;
        r = 8'h00;
        case (code)
            5'h00: r = 8'h02;
            5'h01: r = 8'h04;
            5'h02: r = 8'h06;
            5'h03: r = 8'h08;
            5'h04: r = 8'h0C;
            5'h05: r = 8'h10;
            5'h06: r = 8'h18;
            5'h07: r = 8'h20;
            5'h08: r = 8'h30;
            5'h09: r = 8'h40;
            5'h0A: r = 8'h60;
            5'h0B: r = 8'h80;
            5'h0C: r = 8'hC0;
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        return (a >= OFS_CTRL) && (a <= OFS_FIX_0B);
    endfunction

    logic [DATA_W-1:0] ctrl_w;
    logic [DATA_W-1:0] rate_w;
    logic [DATA_W-1:0] trim_a_w;
    logic [DATA_W-1:0] trim_b_w;
    logic [DATA_W-1:0] output_channel_divisor_w;
    logic en;
    logic burst;
    logic rep;
    logic [PRE_W-1:0] pre_code;
    logic [1:0] pre_lim;
    logic [RATE_W-1:0] rate_div;
    logic [RATE_W-1:0] rate_lim;
    logic [CNT_W-1:0] burst_cnt;
    logic [RATIO_W-1:0] ch_ratio;
    logic rise;
    logic ch_tick;
    logic pre_tick;
    logic rate_tick;
    logic [3:0] widx;

    assign ctrl_w = st.regs[IDX_CTRL];
    assign rate_w = st.regs[IDX_RATE];
    assign trim_a_w = st.regs[IDX_TRIM_A];
    assign trim_b_w = st.regs[IDX_TRIM_B];
    assign output_channel_divisor_w = st.regs[IDX_OUTPUT_CHANNEL_DIVISOR];
    assign en = ctrl_w[EN_BIT];
    assign burst = ctrl_w[BURST_BIT];
    assign rep = ctrl_w[REP_BIT];
    assign pre_code = ctrl_w[PRE_LO +: PRE_W];
    assign rate_div = rate_w[RATE_LO +: RATE_W];
    assign burst_cnt = trim_b_w[CNT_LO +: CNT_W];
    assign ch_ratio = output_channel_divisor_ratio(output_channel_divisor_w[OUTPUT_CHANNEL_DIVISOR_LO +: OUTPUT_CHANNEL_DIVISOR_W]);
    assign widx = 4'(bus_req.addr - OFS_CTRL);

    always_comb begin
        next_st = st;
        rise = st.req_sync & ~st.req_prev;
        pre_lim = (pre_code == PRE_CODE_DIV2) ? PRE_RATIO_2 : PRE_RATIO_4;
        rate_lim = (rate_div == '0) ? RATE_MIN : rate_div;
        // at or past the limit, so a smaller divisor takes hold at once
        ch_tick = (ch_ratio != '0) && (st.ch_cnt >= 8'(ch_ratio - 8'h01));
        pre_tick = ch_tick && (st.pre_cnt >= pre_lim);
        rate_tick = pre_tick && (st.rate_cnt >= 11'(rate_lim - RATE_MIN));

        next_st.rdata = '0;
        if (bus_req.rd && reg_hit(bus_req.addr)) begin
            next_st.rdata = st.regs[widx];
        end
        if (bus_req.wr && reg_hit(bus_req.addr)) begin
            next_st.regs[widx] = bus_req.wdata;
        end

        next_st.req_meta = sref_request_pin;
        next_st.req_sync = st.req_meta;
        next_st.req_prev = st.req_sync;
        next_st.out_div = ch_ratio;
        next_st.pulse = 1'b0;

        if (!en) begin
            next_st.ch_cnt = '0;
            next_st.pre_cnt = '0;
            next_st.rate_cnt = '0;
        end else begin
            next_st.ch_cnt = ch_tick ? '0 : 8'(st.ch_cnt + 8'h01);
            if (ch_tick) begin
                next_st.pre_cnt = pre_tick ? '0 : 2'(st.pre_cnt + 2'h1);
            end
            if (pre_tick) begin
                next_st.rate_cnt = rate_tick ? '0 : 11'(st.rate_cnt + RATE_MIN);
            end
        end

        case (st.mode)
            st_idle: begin
                if (en && burst && rise && (burst_cnt != '0)) begin
                    next_st.mode = st_burst;
                    next_st.left = burst_cnt;
                end else if (en && !burst && !rep) begin
                    next_st.mode = st_run;
                end else if (en && !burst && rep && rise) begin
                    next_st.mode = st_burst;
                    next_st.left = 4'h1;
                end
            end
            st_run: begin
                if (!en || burst || rep) begin
                    next_st.mode = st_idle;
                end else if (rate_tick) begin
                    next_st.pulse = 1'b1;
                end
            end
            st_burst: begin
                if (rate_tick) begin
                    next_st.pulse = 1'b1;
                    next_st.left = 4'(st.left - 4'h1);
                    if (st.left == 4'h1) begin
                        next_st.mode = st_idle;
                    end
                end
            end
            default: begin
                next_st.mode = st_idle;
            end
        endcase

        // enable gates every pulse, new value included
        if (!next_st.regs[IDX_CTRL][EN_BIT]) begin
            next_st.mode = st_idle;
            next_st.pulse = 1'b0;
            next_st.left = '0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st.regs <= REG_RESET;
            st.rdata <= '0;
            st.req_meta <= 1'b0;
            st.req_sync <= 1'b0;
            st.req_prev <= 1'b0;
            st.ch_cnt <= '0;
            st.pre_cnt <= '0;
            st.rate_cnt <= '0;
            st.left <= '0;
            st.mode <= st_idle;
            st.pulse <= 1'b0;
            st.out_div <= 8'h02;
        end else begin
            st <= next_st;
        end
    end

    assign bus_rdata = st.rdata;
    assign sysref_out = st.pulse;
    assign output_channel_divisor = st.out_div;
    assign sref_delay_trim = '{
        trim_4: trim_b_w[TRIM_HI_POS +: TRIM_W],
        trim_3: trim_b_w[TRIM_LO_POS +: TRIM_W],
        trim_2: trim_a_w[TRIM_HI_POS +: TRIM_W],
        trim_1: trim_a_w[TRIM_LO_POS +: TRIM_W]
    };

endmodule // srcd_top

`default_nettype wire

// >>> hdl/srcd_pkg.sv
/*
 * Shared constants and types for the SYSREF and channel divider register slice:
 * register offsets and indices, reset values, field positions, codes, the bus
 * carrier, the delay trim bundle and the block state.
 * Assumes one clock domain and a plain register port with 16-bit words.
 */
`default_nettype none

package srcd_pkg;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;
    localparam int NUM_REGS = 9;
    localparam int TRIM_W = 6;
    localparam int RATE_W = 11;
    localparam int CNT_W = 4;
    localparam int RATIO_W = 8;
    localparam int PRE_W = 3;

    // printed offsets, used as the addresses on the port
    localparam logic [ADDR_W-1:0] OFS_CTRL = 7'h47;
    localparam logic [ADDR_W-1:0] OFS_RATE = 7'h48;
    localparam logic [ADDR_W-1:0] OFS_TRIM_A = 7'h49;
    localparam logic [ADDR_W-1:0] OFS_TRIM_B = 7'h4A;
    localparam logic [ADDR_W-1:0] OFS_OUTPUT_CHANNEL_DIVISOR = 7'h4B;
    localparam logic [ADDR_W-1:0] OFS_FIX_12 = 7'h4C;
    localparam logic [ADDR_W-1:0] OFS_FIX_0A = 7'h4D;
    localparam logic [ADDR_W-1:0] OFS_FIX_100 = 7'h4E;
    localparam logic [ADDR_W-1:0] OFS_FIX_0B = 7'h4F;

    localparam int IDX_CTRL = 0;
    localparam int IDX_RATE = 1;
    localparam int IDX_TRIM_A = 2;
    localparam int IDX_TRIM_B = 3;
    localparam int IDX_OUTPUT_CHANNEL_DIVISOR = 4;

    localparam logic [NUM_REGS-1:0][DATA_W-1:0] REG_RESET = {
        16'h0000, 16'h0064, 16'h0000, 16'h000C, 16'h0800,
        16'h0000, 16'h003F, 16'h0001, 16'h0080
    };

    // control word fields
    localparam int PRE_LO = 5;
    localparam int BURST_BIT = 4;
    localparam int EN_BIT = 3;
    localparam int REP_BIT = 2;
    // rate divisor field
    localparam int RATE_LO = 0;
    // trim and burst count fields
    localparam int TRIM_LO_POS = 0;
    localparam int TRIM_HI_POS = 6;
    localparam int CNT_LO = 12;
    // channel divider field
    localparam int OUTPUT_CHANNEL_DIVISOR_LO = 6;
    localparam int OUTPUT_CHANNEL_DIVISOR_W = 5;

    localparam logic [PRE_W-1:0] PRE_CODE_DIV2 = 3'h2;
    localparam logic [1:0] PRE_RATIO_2 = 2'h1;
    localparam logic [1:0] PRE_RATIO_4 = 2'h3;
    localparam logic [RATE_W-1:0] RATE_MIN = 11'h001;

    typedef enum {
        st_idle,
        st_run,
        st_burst
    } srcd_mode_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } srcd_bus_req_t;

    typedef struct packed {
        logic [TRIM_W-1:0] trim_4;
        logic [TRIM_W-1:0] trim_3;
        logic [TRIM_W-1:0] trim_2;
        logic [TRIM_W-1:0] trim_1;
    } srcd_trim_t;

    typedef struct packed {
        logic [NUM_REGS-1:0][DATA_W-1:0] regs;
        logic [DATA_W-1:0] rdata;
        logic req_meta;
        logic req_sync;
        logic req_prev;
        logic [RATIO_W-1:0] ch_cnt;
        logic [1:0] pre_cnt;
        logic [RATE_W-1:0] rate_cnt;
        logic [CNT_W-1:0] left;
        srcd_mode_t mode;
        logic pulse;
        logic [RATIO_W-1:0] out_div;
    } srcd_state_t;

endpackage

`default_nettype wire

// >>> dv/srcd_properties.sv
/* checker for srcd_top: port assertions over shadow copies of the fields.
   assumes one clk domain and strobes that never overlap */
`timescale 1ns/100ps
`default_nettype none
module srcd_properties (
    input wire logic clk,
    input wire logic rstn,
    input wire srcd_pkg::srcd_bus_req_t bus_req,
    input wire logic [srcd_pkg::DATA_W-1:0] bus_rdata,
    input wire logic sref_request_pin,
    input wire logic sysref_out,
    input wire srcd_pkg::srcd_trim_t sref_delay_trim,
    input wire logic [srcd_pkg::RATIO_W-1:0] output_channel_divisor
);
    import srcd_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    localparam logic [12:0][7:0] RT = {8'hC0, 8'h80, 8'h60, 8'h40, 8'h30, 8'h20, 8'h18,
        8'h10, 8'h0C, 8'h08, 8'h06, 8'h04, 8'h02};
    logic [7:0] ctl;
    logic [10:0] rate;
    logic [4:0] chd;
    logic [11:0] wa;
    logic [15:0] wb;
    logic [5:0] idle;
    logic [4:0] npul;
    logic req_q;
    wire logic rise = sref_request_pin && !req_q;
    wire logic base = rate == 11'h001 && chd == 5'h00;
    wire logic fm = ctl == 8'h48 && base;
    wire logic sm = ctl == 8'h88 && base;
    wire logic rep_only = ctl[4:2] == 3'h3;
    wire logic burst_on = ctl[4] && ctl[3];
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctl <= 8'h80;
            rate <= 11'h001;
            chd <= 5'h00;
            wa <= 12'h03F;
            wb <= 16'h0000;
            idle <= 6'h00;
            npul <= 5'h00;
            req_q <= 1'b0;
        end else begin
            if (bus_req.wr && bus_req.addr == OFS_CTRL) ctl <= bus_req.wdata[7:0];
            if (bus_req.wr && bus_req.addr == OFS_RATE) rate <= bus_req.wdata[10:0];
            if (bus_req.wr && bus_req.addr == OFS_OUTPUT_CHANNEL_DIVISOR) chd <= bus_req.wdata[10:6];
            if (bus_req.wr && bus_req.addr == OFS_TRIM_A) wa <= bus_req.wdata[11:0];
            if (bus_req.wr && bus_req.addr == OFS_TRIM_B) wb <= bus_req.wdata;
            idle <= rise ? 6'h00 : idle + {5'h00, idle != 6'h3F};
            npul <= rise ? 5'h00 : npul + {4'h0, sysref_out};
            req_q <= sref_request_pin;
        end
    end
    // master pulse followed by a steady fast or slow setting
    sequence s_fast_gap;
        sysref_out && fm ##1 fm [*3];
    endsequence
    sequence s_slow_gap;
        sysref_out && sm ##1 sm [*7];
    endsequence
    a_trim_mirror: assert property (sref_delay_trim == {wb[11:0], wa})
        else $error("trim outputs differ from registers");
    a_ratio_decode: assert property (chd < 5'h0D && $stable(chd) |->
        output_channel_divisor == RT[chd[3:0]]) else $error("channel ratio wrong");
    a_off_quiet: assert property (!ctl[3] [*3] |-> !sysref_out)
        else $error("pulse while disabled");
    a_pulse_single: assert property (sysref_out |=> !sysref_out)
        else $error("pulse longer than one cycle");
    a_fast_rate: assert property (s_fast_gap |=> sysref_out)
        else $error("master period not 4");
    a_slow_rate: assert property (s_slow_gap |=> sysref_out)
        else $error("master period not 8");
    a_rep_wait: assert property ((rep_only && base) [*3] ##0 idle > 6'h28 |->
        !sysref_out) else $error("repeater pulse without request");
    a_burst_cap: assert property (burst_on [*3] ##0 sysref_out |->
        npul < {1'b0, wb[15:12]}) else $error("burst too long");
endmodule // srcd_properties
bind srcd_top srcd_properties u_props (.clk(clk), .rstn(rstn), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .sref_request_pin(sref_request_pin), .sysref_out(sysref_out),
    .sref_delay_trim(sref_delay_trim), .output_channel_divisor(output_channel_divisor));
`default_nettype wire

// >>> dv/srcd_req_src.sv
/* request source: raises the request pin for a while, low otherwise.
   assumes the bench clock */
`timescale 1ns/100ps
`default_nettype none
module srcd_req_src (
    input wire logic clk,
    output var logic pin
);
    initial pin = 1'b0;
    task automatic fire(input int hold);
        @(posedge clk);
        pin <= 1'b1;
        repeat (hold) @(posedge clk);
        pin <= 1'b0;
    endtask
endmodule // srcd_req_src
`default_nettype wire

// >>> dv/srcd_top_tb.sv
/* bench for srcd_top: register access, ratio decode, pulse counts.
   assumes srcd_properties is bound to the design */
`timescale 1ns/100ps
`default_nettype none
module srcd_top_tb;
    import srcd_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    srcd_bus_req_t bus_req = '0;
    logic [DATA_W-1:0] bus_rdata;
    logic req_pin;
    logic sysref_out;
    srcd_trim_t trim;
    logic [RATIO_W-1:0] ratio;
    int errors = 0;
    int n_compared = 0;
    localparam logic [8:0][15:0] RST = {16'h0000, 16'h0064, 16'h0000, 16'h000C, 16'h0800,
        16'h0000, 16'h003F, 16'h0001, 16'h0080};
    localparam logic [12:0][7:0] RT = {8'hC0, 8'h80, 8'h60, 8'h40, 8'h30, 8'h20, 8'h18,
        8'h10, 8'h0C, 8'h08, 8'h06, 8'h04, 8'h02};
    localparam logic [15:0] CTL [6] = '{16'h0048, 16'h0088, 16'h0048, 16'h0048, 16'h0040,
        16'h004C};
    localparam logic [15:0] RATE [6] = '{16'h0001, 16'h0001, 16'h0000, 16'h0003, 16'h0001,
        16'h0001};
    localparam int NP [6] = '{12, 6, 12, 4, 0, 0};
    localparam logic [15:0] BCTL [4] = '{16'h0058, 16'h0058, 16'h005C, 16'h005C};
    localparam logic [3:0] BCNT [4] = '{4'h0, 4'hF, 4'h3, 4'hF};
    always #12.5 clk = ~clk;
    srcd_top dut (.clk(clk), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .sref_request_pin(req_pin), .sysref_out(sysref_out), .sref_delay_trim(trim),
        .output_channel_divisor(ratio));
    srcd_req_src req (.clk(clk), .pin(req_pin));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req <= '0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= '0;
        #1 chk("read data", bus_rdata, exp);
    endtask
    task automatic cnt(input int cyc, input int exp);
        int n = 0;
        repeat (cyc) begin
            @(posedge clk);
            #1 n += int'(sysref_out);
        end
        chk("pulse count", 16'(n), 16'(exp));
    endtask
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #2000000;
        errors++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 9; i++) rd(7'h47 + 7'(i), RST[i]);
        wr(7'h50, 16'hFFFF);
        rd(7'h50, 16'h0000);
        chk("ratio", 16'(ratio), 16'h0002);
        wr(7'h4E, 16'h0064);
        wr(7'h4C, 16'h000C);
        wr(7'h49, 16'h0A55);
        rd(7'h49, 16'h0A55);
        chk("trim", 16'(trim[11:0]), 16'h0A55);
        $display("register test done");
        for (int c = 0; c < 13; c++) begin
            wr(7'h4B, 16'h0800 | 16'(c << 6));
            repeat (2) @(posedge clk);
            #1 chk("channel ratio", 16'(ratio), 16'(RT[c]));
        end
        wr(7'h4B, 16'h0B40);
        repeat (2) @(posedge clk);
        #1 chk("invalid ratio", 16'(ratio), 16'h0000);
        wr(7'h4B, 16'h0800);
        $display("ratio test done");
        for (int k = 0; k < 6; k++) begin
            wr(7'h48, RATE[k]);
            wr(7'h47, CTL[k]);
            repeat (30) @(posedge clk);
            cnt(48, NP[k]);
        end
        fork
            req.fire(4);
            cnt(40, 1);
        join
        $display("rate test done");
        for (int k = 0; k < 4; k++) begin
            wr(7'h4A, {BCNT[k], 12'h000});
            wr(7'h47, BCTL[k]);
            repeat (10) @(posedge clk);
            fork
                req.fire(4);
                cnt(90, int'(BCNT[k]));
            join
        end
        $display("burst test done");
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd(7'h47, 16'h0080);
        chk("ratio after reset", 16'(ratio), 16'h0002);
        chk("trim a after reset", 16'(trim[11:0]), 16'h003F);
        chk("trim b after reset", 16'(trim[23:12]), 16'h0000);
        $display("reset test done");
        finish_test();
    end
endmodule // srcd_top_tb
`default_nettype wire
